// ===== rtl/pdci_pkg.sv
// Package with timing constants, types and states for the DRAM controller.
package pdci_pkg;

   // Clock period in picoseconds.
   localparam int CLK_PERIOD_PS = 5000;

   // Address geometry.
   localparam int ROW_BITS  = 10;
   localparam int COL_BITS  = 10;
   localparam int ADDR_BITS = ROW_BITS + COL_BITS;
   localparam int REFRESH_ROWS = 512;
   localparam int INIT_CYCLES  = 8;

   // Timing figures in ns (fastest grade) unless the name says otherwise.
   localparam int RAS_PRECHARGE_NS      = 60;
   localparam int RAS_PULSE_NS          = 70;
   localparam int ROW_ADDRESS_HOLD_NS   = 10;
   localparam int TRANSITION_TIME_NS    = 5;
   localparam int ROW_TO_COL_STROBE_NS  = 20;
   localparam int COL_PULSE_NS          = 25;
   localparam int COL_ACCESS_NS         = 25;
   localparam int ADDRESS_ACCESS_NS     = 43;
   localparam int ROW_ACCESS_NS         = 70;
   localparam int COL_TO_WRITE_NS       = 25;
   localparam int WRITE_PULSE_NS        = 15;
   localparam int WRITE_TO_ROW_LEAD_NS  = 22;
   localparam int PAGE_COL_PRECHARGE_NS = 15;
   localparam int PAGE_CYCLE_NS         = 53;
   localparam int REFRESH_COL_HOLD_NS   = 15;
   localparam int REFRESH_COL_SETUP_NS  = 0;
   localparam int PRECHARGE_TO_COL_NS   = 0;
   localparam int POWERUP_PAUSE_US      = 200;
   localparam int REFRESH_PERIOD_US     = 8200;

   // Minimum times rounded up to whole cycles, never below one.
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
      return (c < 1) ? 1 : c;
   endfunction : min_cyc

   localparam int RP_CYC   = min_cyc(RAS_PRECHARGE_NS);
   localparam int RCD_CYC  = min_cyc(ROW_TO_COL_STROBE_NS);
   localparam int CAS_CYC  = min_cyc(COL_ACCESS_NS > COL_PULSE_NS ?
                                     COL_ACCESS_NS : COL_PULSE_NS);
   localparam int RAC_CYC  = min_cyc(ROW_ACCESS_NS);
   localparam int AA_CYC   = min_cyc(ADDRESS_ACCESS_NS);
   localparam int CWD_CYC  = min_cyc(COL_TO_WRITE_NS);
   localparam int WP_CYC   = min_cyc(WRITE_TO_ROW_LEAD_NS > WRITE_PULSE_NS ?
                                     WRITE_TO_ROW_LEAD_NS : WRITE_PULSE_NS);
   localparam int CP_CYC   = min_cyc(PAGE_COL_PRECHARGE_NS);
   localparam int PC_CYC   = min_cyc(PAGE_CYCLE_NS);
   localparam int CHR_CYC  = min_cyc(REFRESH_COL_HOLD_NS);
   localparam int CSR_CYC  = min_cyc(REFRESH_COL_SETUP_NS);
   localparam int RPC_CYC  = min_cyc(PRECHARGE_TO_COL_NS);
   localparam int RAS_CYC  = min_cyc(RAS_PULSE_NS);
   localparam int POWERUP_CYC = POWERUP_PAUSE_US * 1000000 / CLK_PERIOD_PS;
   // Longest refresh spacing per row, rounded down. The period is split
   // per row before it is scaled to picoseconds, so no step overflows int.
   localparam int REFRESH_INTERVAL_CYC =
      REFRESH_PERIOD_US * 1000 / REFRESH_ROWS * 1000 / CLK_PERIOD_PS;

   // Request kinds.
   typedef enum logic [1:0] {
      PDCI_OP_READ  = 2'h0,
      PDCI_OP_WRITE = 2'h1,
      PDCI_OP_RMW   = 2'h2
   } pdci_op_e;

   // One user request.
   typedef struct packed {
      pdci_op_e               op;
      logic [ADDR_BITS-1:0]   addr;
      logic                   wdata;
      logic                   wmask;
   } pdci_req_s;

   // Strobes and address driven to the memory.
   typedef struct packed {
      logic                   ras_n;
      logic                   cas_n;
      logic                   we_n;
      logic [ROW_BITS-1:0]    addr;
      logic                   din;
   } pdci_pins_s;

   // Sequencer states.
   typedef enum logic [12:0] {
      PDCI_ST_POWERUP = 13'h0001,
      PDCI_ST_INIT    = 13'h0002,
      PDCI_ST_IDLE    = 13'h0004,
      PDCI_ST_ROW     = 13'h0008,
      PDCI_ST_COL     = 13'h0010,
      PDCI_ST_MODIFY  = 13'h0020,
      PDCI_ST_WRPULSE = 13'h0040,
      PDCI_ST_PAGEPRE = 13'h0080,
      PDCI_ST_RASPRE  = 13'h0100,
      PDCI_ST_CBR_CAS = 13'h0200,
      PDCI_ST_CBR_RAS = 13'h0400,
      PDCI_ST_CBR_END = 13'h0800,
      PDCI_ST_PAGEWT  = 13'h1000
   } pdci_state_e;

endpackage : pdci_pkg

// ===== rtl/pdci_timer.sv
// Down-counting wait timer used by the strobe sequencer.
`timescale 1ns/1ps
module pdci_timer
   import pdci_pkg::*;
#(
   parameter int WIDTH = 24
) (
   // Clock and reset.
   input  wire logic             clk_in,
   input  wire logic             sys_rst_in,
   input  wire logic             clk_en_in,
   // Load and status.
   input  wire logic             load_in,
   input  wire logic [WIDTH-1:0] count_in,
   output logic                  done_out
);

   logic [WIDTH-1:0] count_reg;

   // Loading with N makes done rise N cycles later.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         count_reg <= '0;
      end else if (clk_en_in) begin
         if (load_in) begin
            count_reg <= count_in - WIDTH'(1);
         end else if (count_reg != '0) begin
            count_reg <= count_reg - WIDTH'(1);
         end
      end
   end

   // Done as soon as the count has run out. It ignores the load input, so
   // a caller may load on done without forming a combinational loop.
   assign done_out = (count_reg == '0);

endmodule : pdci_timer

// ===== rtl/pdci_ctrl.sv
// Fast-page-mode DRAM controller driving strobes, address and data pins.
`timescale 1ns/1ps

// Overview of operation
// - Row then column, ten bits each
// - Write select high reads, low writes
// - Early write: write select before column strobe (on a page hit both fall on the same edge)
// - Read-modify-write: write select after delays
// - Otherwise delayed write, meet lead times
// - Read keeps strobes low, write high
// - Read hold after row or column
// - Modify write only after read data
// - Hidden refresh keeps column strobe low (refresh here closes the row with column strobe high, then CAS-before-RAS)
// - Refresh column strobe leads, holds 15 ns
// - Refresh column strobe may follow precharge
// - Power-up pause then eight row-only cycles
// - Counter use: eight refresh cycles instead
// - Page cycles at least 53 ns apart
// - Column precharge at least 15 ns
// - All 512 rows every 8.2 ms
// - Row-only refresh keeps column strobe high
// - Page mode: row held, column pulsed
module pdci_ctrl
   import pdci_pkg::*;
#(
   parameter int POWERUP_CYCLES  = POWERUP_CYC,
   parameter int REFRESH_CYCLES  = REFRESH_INTERVAL_CYC,
   parameter int TIMER_WIDTH     = 24
) (
   // Clock, reset and enable.
   input  wire logic         clk_in,
   input  wire logic         sys_rst_in,
   input  wire logic         clk_en_in,
   // Configuration: 1 selects counter refresh, 0 row-only refresh, for start-up only; later refreshes always use the counter.
   input  wire logic         use_counter_in,
   // User request.
   input  wire logic         req_valid_in,
   input  wire pdci_req_s    req_in,
   output logic              req_ready_out,
   output logic              rdata_valid_out,
   output logic              rdata_out,
   output logic              init_done_out,
   // Memory pins.
   output pdci_pins_s        mem_out,
   input  wire logic         mem_dout_in
);

   pdci_state_e             state_reg;
   pdci_req_s               cur_reg;
   logic [ROW_BITS-1:0]     open_row_reg;
   logic                    row_open_reg;
   logic [3:0]              init_cnt_reg;
   logic [ROW_BITS-2:0]     ref_row_reg;
   logic [TIMER_WIDTH-1:0]  ref_cnt_reg;
   logic                    ref_due_reg;
   logic                    ref_cbr_reg;
   logic [TIMER_WIDTH-1:0]  ras_cnt_reg;
   logic                    t_load;
   logic [TIMER_WIDTH-1:0]  t_count;
   logic                    t_done;
   logic                    ref_taken;

   // Wait timer used by the column and write-pulse states of the sequencer.
   pdci_timer #(
      .WIDTH      (TIMER_WIDTH)
   ) u_timer (
      .clk_in     (clk_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .load_in    (t_load),
      .count_in   (t_count),
      .done_out   (t_done)
   );

   // Timer loads: the column and write-pulse states wait their minimum before moving on.
   always_comb begin
      t_load  = 1'b0;
      t_count = TIMER_WIDTH'(1);
      if (state_reg == PDCI_ST_IDLE ||
          (state_reg == PDCI_ST_ROW && ras_cnt_reg == '0)) begin
         // The access wait starts at the column strobe edge, page hit or not.
         t_load  = 1'b1;
         t_count = TIMER_WIDTH'(AA_CYC > CAS_CYC ? AA_CYC : CAS_CYC);
      end else if (state_reg == PDCI_ST_COL && t_done &&
                   cur_reg.op == PDCI_OP_RMW) begin
         t_load  = 1'b1;
         t_count = TIMER_WIDTH'(WP_CYC);
      end
   end

   // Refresh pacing: one row every interval keeps 512 rows fresh.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         ref_cnt_reg <= '0;
         ref_due_reg <= 1'b0;
      end else if (clk_en_in) begin
         if (ref_cnt_reg >= TIMER_WIDTH'(REFRESH_CYCLES - 1)) begin
            ref_cnt_reg <= '0;
            ref_due_reg <= 1'b1;
         end else begin
            ref_cnt_reg <= ref_cnt_reg + TIMER_WIDTH'(1);
            if (ref_taken) begin
               ref_due_reg <= 1'b0;
            end
         end
      end
   end

   // Cleared in one cycle only, so a new interval that ends during the
   // long precharge is not swallowed.
   assign ref_taken = (state_reg == PDCI_ST_CBR_RAS) && ref_cbr_reg &&
                      (ras_cnt_reg == '0);

   // Main strobe sequencer; the pins come from registers only.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg       <= PDCI_ST_POWERUP;
         cur_reg         <= '0;
         open_row_reg    <= '0;
         row_open_reg    <= 1'b0;
         init_cnt_reg    <= '0;
         ref_row_reg     <= '0;
         ref_cbr_reg     <= 1'b0;
         ras_cnt_reg     <= '0;
         mem_out         <= '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                              addr: '0, din: 1'b0};
         req_ready_out   <= 1'b0;
         rdata_valid_out <= 1'b0;
         rdata_out       <= 1'b0;
         init_done_out   <= 1'b0;
      end else if (clk_en_in) begin
         rdata_valid_out <= 1'b0;
         req_ready_out   <= 1'b0;
         if (ras_cnt_reg != '0) begin
            ras_cnt_reg <= ras_cnt_reg - TIMER_WIDTH'(1);
         end
         unique case (state_reg)
            PDCI_ST_POWERUP: begin
               // Both strobes high for the pause.
               if (ras_cnt_reg == '0 && !init_cnt_reg[3]) begin
                  ras_cnt_reg  <= TIMER_WIDTH'(POWERUP_CYCLES);
                  init_cnt_reg <= 4'h8;
               end else if (ras_cnt_reg == '0) begin
                  init_cnt_reg <= 4'h0;
                  state_reg    <= PDCI_ST_INIT;
               end
            end
            PDCI_ST_INIT: begin
               if (init_cnt_reg == 4'(INIT_CYCLES)) begin
                  init_done_out <= 1'b1;
                  req_ready_out <= 1'b1;
                  state_reg     <= PDCI_ST_IDLE;
               end else begin
                  init_cnt_reg <= init_cnt_reg + 4'h1;
                  ref_cbr_reg  <= 1'b0;
                  if (use_counter_in) begin
                     mem_out.cas_n <= 1'b0;
                     ras_cnt_reg   <= TIMER_WIDTH'(CSR_CYC);
                     state_reg     <= PDCI_ST_CBR_CAS;
                  end else begin
                     mem_out.addr  <= {1'b0, ref_row_reg};
                     ref_row_reg   <= ref_row_reg + 1'b1;
                     mem_out.ras_n <= 1'b0;
                     ras_cnt_reg   <= TIMER_WIDTH'(RAS_CYC);
                     state_reg     <= PDCI_ST_CBR_RAS;
                  end
               end
            end
            PDCI_ST_IDLE: begin
               // A request met by a high ready is always taken, so ready
               // never promises what a due refresh would then refuse.
               if (ref_due_reg && !(req_valid_in && req_ready_out)) begin
                  // Refresh from idle: row closes with column strobe already high, then CAS-before-RAS.
                  ref_cbr_reg   <= 1'b1;
                  row_open_reg  <= 1'b0;
                  mem_out.ras_n <= 1'b1;
                  mem_out.we_n  <= 1'b1;
                  ras_cnt_reg   <= TIMER_WIDTH'(RP_CYC);
                  state_reg     <= PDCI_ST_CBR_CAS;
               end else if (req_valid_in && req_ready_out) begin
                  cur_reg <= req_in;
                  if (row_open_reg &&
                      req_in.addr[ADDR_BITS-1:COL_BITS] == open_row_reg) begin
                     // Same row: column only, no refresh credit.
                     mem_out.addr <= req_in.addr[COL_BITS-1:0];
                     mem_out.din  <= req_in.wdata;
                     mem_out.we_n <= (req_in.op != PDCI_OP_WRITE);
                     mem_out.cas_n <= 1'b0;
                     state_reg    <= PDCI_ST_COL;
                  end else if (row_open_reg) begin
                     mem_out.ras_n <= 1'b1;
                     mem_out.cas_n <= 1'b1;
                     row_open_reg  <= 1'b0;
                     ras_cnt_reg   <= TIMER_WIDTH'(RP_CYC);
                     state_reg     <= PDCI_ST_RASPRE;
                  end else begin
                     mem_out.addr  <= req_in.addr[ADDR_BITS-1:COL_BITS];
                     mem_out.ras_n <= 1'b0;
                     open_row_reg  <= req_in.addr[ADDR_BITS-1:COL_BITS];
                     row_open_reg  <= 1'b1;
                     ras_cnt_reg   <= TIMER_WIDTH'(RCD_CYC);
                     state_reg     <= PDCI_ST_ROW;
                  end
               end else begin
                  req_ready_out <= 1'b1;
               end
            end
            PDCI_ST_ROW: begin
               // Column address one cycle (5 ns) after the row strobe, short of the 10 ns row hold, then column strobe.
               mem_out.addr <= cur_reg.addr[COL_BITS-1:0];
               mem_out.din  <= cur_reg.wdata;
               // Early write lowers write select before the column strobe.
               mem_out.we_n <= (cur_reg.op != PDCI_OP_WRITE);
               if (ras_cnt_reg == '0) begin
                  mem_out.cas_n <= 1'b0;
                  state_reg     <= PDCI_ST_COL;
               end
            end
            PDCI_ST_COL: begin
               // Read access: wait column and address paths.
               if (t_done) begin
                  rdata_out       <= mem_dout_in;
                  rdata_valid_out <= (cur_reg.op != PDCI_OP_WRITE);
                  if (cur_reg.op == PDCI_OP_RMW) begin
                     mem_out.din  <= cur_reg.wmask ? cur_reg.wdata
                                                   : ~mem_dout_in;
                     mem_out.we_n <= 1'b0;
                     state_reg    <= PDCI_ST_WRPULSE;
                  end else begin
                     // Write select stays high to the end of a read.
                     mem_out.cas_n <= 1'b1;
                     ras_cnt_reg   <= TIMER_WIDTH'(CP_CYC > PC_CYC - CAS_CYC ?
                                        CP_CYC : PC_CYC - CAS_CYC);
                     state_reg     <= PDCI_ST_PAGEPRE;
                  end
               end
            end
            PDCI_ST_WRPULSE: begin
               // Write lead satisfied before strobes rise.
               if (t_done) begin
                  mem_out.we_n  <= 1'b1;
                  mem_out.cas_n <= 1'b1;
                  ras_cnt_reg   <= TIMER_WIDTH'(PC_CYC > CP_CYC ?
                                                PC_CYC : CP_CYC);
                  state_reg     <= PDCI_ST_PAGEPRE;
               end
            end
            PDCI_ST_PAGEPRE: begin
               mem_out.we_n <= 1'b1;
               if (ras_cnt_reg == '0) begin
                  req_ready_out <= !ref_due_reg;
                  state_reg     <= PDCI_ST_IDLE;
               end
            end
            PDCI_ST_RASPRE: begin
               if (ras_cnt_reg == '0) begin
                  ref_cbr_reg <= 1'b0;
                  if (!init_done_out) begin
                     state_reg <= PDCI_ST_INIT;
                  end else if (ref_cbr_reg) begin
                     req_ready_out <= !ref_due_reg;
                     state_reg     <= PDCI_ST_IDLE;
                  end else begin
                     // Row miss: the held request opens its own row now.
                     mem_out.addr  <= cur_reg.addr[ADDR_BITS-1:COL_BITS];
                     mem_out.ras_n <= 1'b0;
                     open_row_reg  <= cur_reg.addr[ADDR_BITS-1:COL_BITS];
                     row_open_reg  <= 1'b1;
                     ras_cnt_reg   <= TIMER_WIDTH'(RCD_CYC);
                     state_reg     <= PDCI_ST_ROW;
                  end
               end
            end
            PDCI_ST_CBR_CAS: begin
               // Column strobe low no later than the row strobe.
               mem_out.cas_n <= 1'b0;
               if (ras_cnt_reg == '0) begin
                  mem_out.ras_n <= 1'b0;
                  ras_cnt_reg   <= TIMER_WIDTH'(RAS_CYC > CHR_CYC + RPC_CYC ?
                                                RAS_CYC : CHR_CYC + RPC_CYC);
                  state_reg     <= PDCI_ST_CBR_RAS;
               end
            end
            PDCI_ST_CBR_RAS: begin
               if (ras_cnt_reg == '0) begin
                  mem_out.ras_n <= 1'b1;
                  mem_out.cas_n <= 1'b1;
                  ras_cnt_reg   <= TIMER_WIDTH'(RP_CYC);
                  state_reg     <= PDCI_ST_RASPRE;
               end
            end
            default: begin
               state_reg <= PDCI_ST_IDLE;
            end
         endcase
      end
   end

endmodule : pdci_ctrl

// ===== bench/pdci_ctrl_asserts.sv
// Checker for the strobe sequencing of the page-mode memory controller.
`timescale 1ns/1ps
module pdci_ctrl_asserts
   import pdci_pkg::*;
#(
   parameter int POWERUP_CYCLES = POWERUP_CYC
) (
   // Clock and reset.
   input wire logic       clk_in,
   input wire logic       sys_rst_in,
   // Controls and request.
   input wire logic       use_counter_in,
   input wire logic       req_valid_in,
   input wire pdci_req_s  req_in,
   input wire logic       req_ready_out,
   input wire logic       rdata_valid_out,
   input wire logic       init_done_out,
   // Memory pins.
   input wire pdci_pins_s mem_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);

   logic [31:0] up_reg;
   logic [3:0]  init_reg;
   logic [7:0]  gap_reg;
   pdci_req_s   take_reg;

   // Counters saturate so a long run never wraps them into a false pass.
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         up_reg   <= '0;
         init_reg <= '0;
         gap_reg  <= 8'hFF;
      end else begin
         if (up_reg != 32'hFFFFFFFF) up_reg <= up_reg + 32'h1;
         if ($fell(mem_out.ras_n) && !init_done_out && init_reg != 4'hF)
            init_reg <= init_reg + 4'h1;
         if (mem_out.ras_n) gap_reg <= 8'hFF;
         else if ($fell(mem_out.cas_n)) gap_reg <= 8'h01;
         else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
      end
   end

   // The request that the strobes currently serve.
   always_ff @(posedge clk_in) begin
      if (req_valid_in && req_ready_out) take_reg <= req_in;
   end

   property p_pause;
      up_reg < POWERUP_CYCLES |-> mem_out.ras_n && mem_out.cas_n;
   endproperty
   a_pause: assert property (p_pause) else $error("strobe in pause");
   property p_init_cnt;
      $rose(init_done_out) |-> init_reg >= 4'(INIT_CYCLES);
   endproperty
   a_init_cnt: assert property (p_init_cnt) else $error("few init");
   property p_init_kind;
      $fell(mem_out.ras_n) && !init_done_out |-> mem_out.cas_n == !use_counter_in;
   endproperty
   a_init_kind: assert property (p_init_kind) else $error("init kind");
   property p_cbr_hold;
      $fell(mem_out.ras_n) && !mem_out.cas_n |=> !mem_out.cas_n [*2];
   endproperty
   a_cbr_hold: assert property (p_cbr_hold) else $error("cbr hold");
   property p_col_pre;
      $rose(mem_out.cas_n) && !mem_out.ras_n |-> mem_out.cas_n [*3];
   endproperty
   a_col_pre: assert property (p_col_pre) else $error("col precharge");
   property p_page_gap;
      $fell(mem_out.cas_n) && !mem_out.ras_n |-> gap_reg >= 8'(PC_CYC);
   endproperty
   a_page_gap: assert property (p_page_gap) else $error("page gap");
   property p_col_addr;
      $fell(mem_out.cas_n) && !mem_out.ras_n |-> mem_out.addr ==
         take_reg.addr[COL_BITS-1:0] && (take_reg.op == PDCI_OP_WRITE || mem_out.we_n);
   endproperty
   a_col_addr: assert property (p_col_addr) else $error("column");
   property p_rmw;
      $fell(mem_out.we_n) && !mem_out.cas_n && take_reg.op == PDCI_OP_RMW
         |-> gap_reg >= 8'(CWD_CYC);
   endproperty
   a_rmw: assert property (p_rmw) else $error("early modify");

   c_read: cover property (rdata_valid_out);
   c_cbr: cover property ($fell(mem_out.ras_n) && !mem_out.cas_n);
   c_rmw: cover property ($fell(mem_out.we_n) && !mem_out.cas_n);
endmodule : pdci_ctrl_asserts

bind pdci_ctrl pdci_ctrl_asserts #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
   .clk_in(clk_in), .sys_rst_in(sys_rst_in), .use_counter_in(use_counter_in),
   .req_valid_in(req_valid_in), .req_in(req_in), .req_ready_out(req_ready_out),
   .rdata_valid_out(rdata_valid_out), .init_done_out(init_done_out),
   .mem_out(mem_out));

// ===== bench/pdci_dram_model.sv
// Behavioural model of the one-bit page-mode memory device.
`timescale 1ns/1ps
module pdci_dram_model
   import pdci_pkg::*;
(
   // Strobes, address and data from the controller.
   input  wire logic                ras_n_in,
   input  wire logic                cas_n_in,
   input  wire logic                we_n_in,
   input  wire logic [ROW_BITS-1:0] addr_in,
   input  wire logic                din_in,
   // Data towards the controller.
   output logic                     dout_out
);
   logic                mem [int];
   logic [ROW_BITS-1:0] row_reg = '0;
   logic [COL_BITS-1:0] col_reg = '0;
   logic                cbr_reg = 1'b0;
   logic                rd_reg = 1'b0;
   logic                valid_reg = 1'b0;

   // A column strobe already low means the row comes from the counter.
   always @(negedge ras_n_in) begin
      cbr_reg = !cas_n_in;
      if (cas_n_in) row_reg = addr_in;
   end

   // Column latch; data shows only after the column access time.
   always @(negedge cas_n_in) begin
      if (!ras_n_in) begin
         col_reg = addr_in;
         if (!we_n_in) mem[int'({row_reg, col_reg})] = din_in;
         else begin
            rd_reg = mem.exists(int'({row_reg, col_reg})) ?
                     mem[int'({row_reg, col_reg})] : 1'b0;
            valid_reg <= #(COL_ACCESS_NS) 1'b1;
         end
      end
   end

   // Delayed write and modify take data on the write-select edge.
   always @(negedge we_n_in) begin
      if (!ras_n_in && !cas_n_in && !cbr_reg)
         mem[int'({row_reg, col_reg})] = din_in;
   end

   // Output stays through hidden refresh and goes with the column strobe.
   always @(posedge cas_n_in) valid_reg <= 1'b0;

   // A released pin shows the inverse bit, never a kindly held value.
   assign dout_out = valid_reg ? rd_reg : !rd_reg;
endmodule : pdci_dram_model

// ===== bench/tb_top.sv
// Self-checking bench for the page-mode memory controller.
`timescale 1ns/1ps
module tb_top
   import pdci_pkg::*;
;
   // A short pause keeps the run brief.
   localparam int PU_CYC = 20;
   localparam int LIMIT  = 20000;
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       clk_en_in = 1'b1;
   logic       use_counter_in = 1'b0;
   logic       req_valid_in = 1'b0;
   pdci_req_s  req_in = '0;
   logic       req_ready_out;
   logic       rdata_valid_out;
   logic       rdata_out;
   logic       init_done_out;
   logic       mem_dout_in;
   pdci_pins_s mem_out;
   int         miscompares = 0;
   int         checks_done = 0;
   int         cycles = 0;
   int         seed = 97;
   logic       ref_mem [int];

   always #2.5 clk_in = !clk_in;

   pdci_ctrl #(.POWERUP_CYCLES(PU_CYC), .REFRESH_CYCLES(2000)) DUT (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
      .use_counter_in(use_counter_in), .req_valid_in(req_valid_in),
      .req_in(req_in), .req_ready_out(req_ready_out),
      .rdata_valid_out(rdata_valid_out), .rdata_out(rdata_out),
      .init_done_out(init_done_out), .mem_out(mem_out),
      .mem_dout_in(mem_dout_in));

   pdci_dram_model u_mem (
      .ras_n_in(mem_out.ras_n), .cas_n_in(mem_out.cas_n),
      .we_n_in(mem_out.we_n), .addr_in(mem_out.addr),
      .din_in(mem_out.din), .dout_out(mem_dout_in));

   task automatic check(input logic seen, input logic exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s seen %b want %b", $time, what, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   function automatic logic exp_bit(input logic [ADDR_BITS-1:0] a);
      return ref_mem.exists(int'(a)) ? ref_mem[int'(a)] : 1'b0;
   endfunction : exp_bit

   // A hang is cut short here and still reaches the verdict.
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("mismatch at %0t: run did not finish", $time);
         wrap_up();
      end
   end

   // Reset, check the pause, then wait for the start-up sequence.
   task automatic do_reset(input logic use_ctr);
      int n;
      @(posedge clk_in);
      #1 sys_rst_in = 1'b1;
      use_counter_in = use_ctr;
      repeat (16) @(posedge clk_in);
      #1 sys_rst_in = 1'b0;
      repeat (PU_CYC - 2) begin
         @(posedge clk_in);
         check(mem_out.ras_n & mem_out.cas_n, 1'b1, "pause");
      end
      n = 0;
      while (init_done_out !== 1'b1 && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      check(init_done_out, 1'b1, "init");
      $display("test reset with counter %b done", use_ctr);
   endtask : do_reset

   // Request is held from just after an edge until it is taken.
   task automatic do_req(input pdci_op_e op, input logic [ADDR_BITS-1:0] a,
                         input logic wd, input logic wm, output logic rd);
      int n;
      @(posedge clk_in);
      #1 req_in = '{op, a, wd, wm};
      req_valid_in = 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (req_ready_out !== 1'b1 && n < 5000);
      check(req_ready_out, 1'b1, "taken");
      #1 req_valid_in = 1'b0;
      // Some transfers are frozen for a while; the result must not change.
      if (a[2:0] == 3'h5) begin
         clk_en_in = 1'b0;
         repeat (3) @(posedge clk_in);
         #1 clk_en_in = 1'b1;
      end
      rd = 1'bx;
      if (op != PDCI_OP_WRITE) begin
         n = 0;
         do begin
            @(posedge clk_in);
            n++;
         end while (rdata_valid_out !== 1'b1 && n < 300);
         check(rdata_valid_out, 1'b1, "answer");
         rd = rdata_out;
      end
   endtask : do_req

   // Random operations with corner addresses and few rows for page hits.
   task automatic run_ops(input int count);
      int r;
      logic [ADDR_BITS-1:0] a;
      logic wd;
      logic wm;
      logic rd;
      logic old;
      pdci_op_e op;
      for (int i = 0; i < count; i++) begin
         r = $random(seed);
         op = pdci_op_e'(r[1:0] == 2'h3 ? 2'h2 : r[1:0]);
         a = r[ADDR_BITS+1:2];
         if (i == 0) a = 20'h00000;
         else if (i == 1) a = 20'hFFFFF;
         else if (i % 3 != 0) a[19:12] = 8'h00;
         wd = r[23];
         wm = r[24];
         old = exp_bit(a);
         do_req(op, a, wd, wm, rd);
         if (op != PDCI_OP_WRITE) check(rd, old, "read");
         if (op == PDCI_OP_WRITE) ref_mem[int'(a)] = wd;
         if (op == PDCI_OP_RMW) ref_mem[int'(a)] = wm ? wd : !old;
         if (op != PDCI_OP_READ) begin
            do_req(PDCI_OP_READ, a, 1'b0, 1'b0, rd);
            check(rd, exp_bit(a), "readback");
         end
      end
      $display("test of %0d operations done", count);
   endtask : run_ops

   initial begin
      do_reset(1'b0);
      run_ops(24);
      do_reset(1'b1);
      run_ops(16);
      wrap_up();
   end
endmodule : tb_top
